//--- issue_stall_ctrl.v
`timescale 1ns/1ps
`include "issue_stall_defines.vh"
module issue_stall_ctrl (
  // clock and reset
  input  wire        ref_clk_in,
  input  wire        reset_in,
  // decode-stage instruction
  input  wire        instr_valid_in,
  input  wire [31:0] instr_in,
  input  wire [31:0] instr_pc_in,
  input  wire        kernel_mode_in,
  input  wire        is_load_in,
  input  wire        is_store_in,
  input  wire        is_trap_in,
  input  wire        is_io_in,
  input  wire        is_flush_in,
  input  wire        writes_reg_in,
  input  wire [5:0]  write_reg_in,
  // register file read data
  input  wire [31:0] dest_data_in,
  input  wire [31:0] base_data_in,
  // caches
  input  wire        cache_miss_in,
  input  wire        flush_line_in,
  input  wire        flush_dirty_in,
  input  wire        flush_done_in,
  // coprocessor
  input  wire        cp_issue_in,
  input  wire [1:0]  cp_format_in,
  input  wire [1:0]  cp_op_in,
  input  wire        cp_done_in,
  // io
  input  wire        io_busy_in,
  input  wire        io_bus_stall_in,
  // outputs
  output reg         issue_out,
  output reg         stall_out,
  output reg         halt_out,
  output reg         trap_redirect_out,
  output reg  [31:0] program_status_word_out,
  output reg  [31:0] trapping_pc_slot_out,
  output reg  [31:0] next_pc_slot_out,
  output reg  [31:0] a_operand_latch_out,
  output reg  [31:0] b_operand_latch_out,
  output reg  [31:0] dcache_address_reg_out,
  output reg  [31:0] result_latch_out,
  output reg         rf_write_out,
  output reg  [5:0]  rf_write_addr_out,
  output reg  [31:0] rf_write_data_out
);
  // coprocessor latency by format (0 single,1 double,2 fix) and op
  function [5:0] cp_latency;
    input [1:0] fmt;
    input [1:0] op;
    begin
      case ({fmt, op})
        4'h0:    cp_latency = `CP_SP_ADD;
        4'h1:    cp_latency = `CP_SP_MUL;
        4'h2:    cp_latency = `CP_SP_DIV;
        4'h3:    cp_latency = `CP_SP_FLT;
        4'h4:    cp_latency = `CP_DP_ADD;
        4'h5:    cp_latency = `CP_DP_MUL;
        4'h6:    cp_latency = `CP_DP_DIV;
        4'h7:    cp_latency = `CP_DP_FLT;
        4'h8:    cp_latency = `CP_FX_ADD;
        4'h9:    cp_latency = `CP_FX_MUL;
        4'hA:    cp_latency = `CP_FX_DIV;
        default: cp_latency = 6'h01;
      endcase
    end
  endfunction

  wire [3:0]  opc      = instr_in[`OPC_HI:`OPC_LO];
  wire [5:0]  dest_reg_field = instr_in[`DEST_HI:`DEST_LO];
  wire [5:0]  base_reg_field = instr_in[`BASE_HI:`BASE_LO];
  wire [15:0] disp     = instr_in[`DISP_HI:`DISP_LO];
  wire is_la    = (opc == `OP_LOAD_ADDR);
  wire is_undef = (opc == `OP_UNDEF_A) || (opc == `OP_UNDEF_B);
  wire is_mem   = is_load_in || is_store_in;

  reg       prev_wr_reg;
  reg [5:0] prev_waddr_reg;
  reg       prev_store_reg;
  reg       interlock_done_reg;
  reg       store_done_reg;
  reg [3:0] trap_cnt_reg;
  reg [3:0] miss_cnt_reg;
  reg [3:0] flush_cnt_reg;
  reg       flush_active_reg;
  reg       ex_la_reg;
  reg [5:0] ex_dest_reg;
  reg       wr_la_reg;
  reg [5:0] wr_dest_reg;
  wire      cp_busy;

  stall_counter #(.W(6)) u_cp_wait (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .load_in    (go && cp_issue_in),
    .count_in   (cp_latency(cp_format_in, cp_op_in) - 6'h01),
    .done_in    (cp_done_in),
    .busy_out   (cp_busy)
  );

  // decode holds a word until it sees issue_out, so the word seen on the
  // edge right after an issue is stale and must not issue a second time
  wire fresh     = instr_valid_in && !issue_out;
  wire interlock = fresh && is_la && prev_wr_reg &&
                   (prev_waddr_reg == base_reg_field) && !interlock_done_reg;
  wire store_gap = fresh && is_mem && prev_store_reg && !store_done_reg;
  wire cp_wait   = fresh && cp_issue_in && cp_busy;
  wire io_wait   = fresh && is_io_in && (io_busy_in || io_bus_stall_in);
  wire trap_wait = (trap_cnt_reg != 4'h0);
  wire miss_wait = cache_miss_in || (miss_cnt_reg != 4'h0);
  wire flush_wait = (fresh && is_flush_in && !flush_done_in) ||
                    (flush_cnt_reg != 4'h0);
  // any one condition is enough to hold; all must clear to go
  wire stall_any = interlock | store_gap | cp_wait | io_wait | trap_wait |
                   miss_wait | flush_wait | halt_out;
  wire go = fresh && !stall_any;
  wire take_trap = go && ((is_undef && !kernel_mode_in) || is_trap_in);

  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      issue_out               <= 1'b0;
      stall_out               <= 1'b0;
      halt_out                <= 1'b0;
      trap_redirect_out       <= 1'b0;
      program_status_word_out <= 32'h0000_0000;
      trapping_pc_slot_out    <= 32'h0000_0000;
      next_pc_slot_out        <= 32'h0000_0000;
      a_operand_latch_out     <= 32'h0000_0000;
      b_operand_latch_out     <= 32'h0000_0000;
      dcache_address_reg_out  <= 32'h0000_0000;
      result_latch_out        <= 32'h0000_0000;
      rf_write_out            <= 1'b0;
      rf_write_addr_out       <= 6'h00;
      rf_write_data_out       <= 32'h0000_0000;
      prev_wr_reg             <= 1'b0;
      prev_waddr_reg          <= 6'h00;
      prev_store_reg          <= 1'b0;
      interlock_done_reg      <= 1'b0;
      store_done_reg          <= 1'b0;
      trap_cnt_reg            <= 4'h0;
      miss_cnt_reg            <= 4'h0;
      flush_cnt_reg           <= 4'h0;
      flush_active_reg        <= 1'b0;
      ex_la_reg               <= 1'b0;
      ex_dest_reg             <= 6'h00;
      wr_la_reg               <= 1'b0;
      wr_dest_reg             <= 6'h00;
    end else begin
      issue_out         <= go;
      stall_out         <= fresh && stall_any;
      trap_redirect_out <= 1'b0;
      // one-cycle bubbles: mark them served so the next cycle proceeds
      interlock_done_reg <= interlock;
      store_done_reg     <= store_gap;
      if (go) begin
        prev_wr_reg    <= writes_reg_in || is_la;
        prev_waddr_reg <= is_la ? dest_reg_field : write_reg_in;
        prev_store_reg <= is_store_in;
      end else if (interlock || store_gap) begin
        prev_wr_reg    <= 1'b0;
        prev_store_reg <= 1'b0;
      end
      // miss: hold for the miss time counted from the miss cycle
      if (cache_miss_in && miss_cnt_reg == 4'h0)
        miss_cnt_reg <= `MISS_CYCLES - 4'h1;
      else if (miss_cnt_reg != 4'h0)
        miss_cnt_reg <= miss_cnt_reg - 4'h1;
      // flush: a reported line loads its cost only when no earlier line is still counting
      flush_active_reg <= fresh && is_flush_in && !flush_done_in;
      if (flush_line_in && flush_cnt_reg == 4'h0)
        flush_cnt_reg <= (flush_dirty_in ? `FLUSH_DIRTY_CYC : `FLUSH_CLEAN_CYC)
                         - 4'h1;
      else if (flush_cnt_reg != 4'h0)
        flush_cnt_reg <= flush_cnt_reg - 4'h1;
      // trap: three dead cycles, then redirect to vector zero
      if (take_trap)
        trap_cnt_reg <= `TRAP_CYCLES;
      else if (trap_cnt_reg != 4'h0) begin
        trap_cnt_reg <= trap_cnt_reg - 4'h1;
        if (trap_cnt_reg == 4'h1)
          trap_redirect_out <= 1'b1;
      end
      if (go && is_undef && !kernel_mode_in) begin
        program_status_word_out[`PSW_ILLEGAL_BIT] <= 1'b1;
        trapping_pc_slot_out <= instr_pc_in;
        next_pc_slot_out     <= instr_pc_in + 32'h0000_0001;
      end
      if (go && is_undef) begin
        a_operand_latch_out <= dest_data_in;
        b_operand_latch_out <= base_data_in;
        if (kernel_mode_in) begin
          halt_out         <= 1'b1;
          next_pc_slot_out <= instr_pc_in + 32'h0000_0001;
        end
      end
      // load address: decode, execute, writeback
      if (go && is_la)
        dcache_address_reg_out <= {2'b00, base_data_in[31:2]} +
                                  {{16{disp[15]}}, disp};
      ex_la_reg   <= go && is_la;
      ex_dest_reg <= dest_reg_field;
      if (ex_la_reg)
        result_latch_out <= dcache_address_reg_out;
      wr_la_reg   <= ex_la_reg;
      wr_dest_reg <= ex_dest_reg;
      rf_write_out      <= wr_la_reg;
      rf_write_addr_out <= wr_dest_reg;
      if (wr_la_reg)
        rf_write_data_out <= result_latch_out;
    end
  end
endmodule // issue_stall_ctrl

//--- issue_stall_defines.vh
// Behaviour
// - load address: (base >> 2) + signed displacement
// - address in decode, latch execute, write writeback
// - base written by previous instruction: stall one
// - user undefined opcode: trap bit, both slots
// - kernel undefined opcode: halt, operand latches loaded
// - issue one instruction per unstalled fresh word, never on two cycles in a row
// - cache miss holds pipeline about thirteen cycles
// - wait for coprocessor, up to fifty-eight cycles
// - coprocessor latency table per operation and format
// - add may take three or four: track completion
// - io after pending io stalls until done
// - io tolerates unbounded bus and select stalls
`ifndef ISSUE_STALL_DEFINES_VH
`define ISSUE_STALL_DEFINES_VH
`define OP_LOAD_ADDR      4'hD
`define OP_UNDEF_A        4'hE
`define OP_UNDEF_B        4'hF
`define OPC_HI            31
`define OPC_LO            28
`define DEST_HI           27
`define DEST_LO           22
`define BASE_HI           21
`define BASE_LO           16
`define DISP_HI           15
`define DISP_LO           0
`define PSW_ILLEGAL_BIT   0
`define TRAP_CYCLES       4'h3
`define MISS_CYCLES       4'hD
`define FLUSH_CLEAN_CYC   4'h3
`define FLUSH_DIRTY_CYC   4'hD
`define TRAP_VECTOR       32'h0000_0000
// coprocessor latencies, issue cycle included
`define CP_SP_ADD   6'h04
`define CP_SP_MUL   6'h08
`define CP_SP_DIV   6'h1D
`define CP_SP_FLT   6'h03
`define CP_DP_ADD   6'h04
`define CP_DP_MUL   6'h12
`define CP_DP_DIV   6'h3A
`define CP_DP_FLT   6'h03
`define CP_FX_ADD   6'h01
`define CP_FX_MUL   6'h06
`define CP_FX_DIV   6'h22
`endif

//--- stall_counter.v
`timescale 1ns/1ps
`include "issue_stall_defines.vh"
module stall_counter #(
  parameter W = 6
) (
  // clock and reset
  input  wire         ref_clk_in,
  input  wire         reset_in,
  // load and early finish
  input  wire         load_in,
  input  wire [W-1:0] count_in,
  input  wire         done_in,
  // status
  output wire         busy_out
);
  reg [W-1:0] count_reg;
  reg [W-1:0] count_next;
  always @* begin
    count_next = count_reg;
    if (load_in)
      count_next = count_in;
    else if (done_in)
      count_next = {W{1'b0}};
    else if (count_reg != {W{1'b0}})
      count_next = count_reg - {{(W-1){1'b0}}, 1'b1};
  end
  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in)
      count_reg <= {W{1'b0}};
    else
      count_reg <= count_next;
  end
  assign busy_out = (count_reg != {W{1'b0}});
endmodule // stall_counter

//--- issue_stall_chk_assertions.sv
`timescale 1ns/1ps
module issue_stall_chk (
  // watched ports
  input wire        ref_clk_in, reset_in, instr_valid_in, kernel_mode_in, is_trap_in,
  input wire        is_io_in, cache_miss_in, io_busy_in, io_bus_stall_in, issue_out,
  input wire        halt_out, rf_write_out, trap_redirect_out,
  input wire [31:0] instr_in, base_data_in, program_status_word_out,
  input wire [31:0] dcache_address_reg_out, result_latch_out, rf_write_data_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  wire        la = instr_valid_in && instr_in[31:28] == 4'hD;
  wire        ud = instr_valid_in && instr_in[31:29] == 3'b111;
  wire [31:0] ea = (base_data_in >> 2) + {{16{instr_in[15]}}, instr_in[15:0]};
  property p_la_addr;
    issue_out && $past(la) |-> dcache_address_reg_out == $past(ea);
  endproperty
  a_la_addr: assert property (p_la_addr) else $error("load address wrong");
  property p_la_pipe;
    issue_out && $past(la) |=> result_latch_out == $past(dcache_address_reg_out)
      ##1 rf_write_out && rf_write_data_out == $past(result_latch_out);
  endproperty
  a_la_pipe: assert property (p_la_pipe) else $error("address pipeline wrong");
  property p_user_undef;
    issue_out && $past(ud && !kernel_mode_in) |-> ##[0:3] program_status_word_out[0];
  endproperty
  a_user_undef: assert property (p_user_undef) else $error("illegal bit not set");
  property p_psw_sticky;
    program_status_word_out[0] |=> program_status_word_out[0];
  endproperty
  a_psw_sticky: assert property (p_psw_sticky) else $error("illegal bit lost");
  property p_kern_halt;
    issue_out && $past(ud && kernel_mode_in) |-> ##[0:3] halt_out;
  endproperty
  a_kern_halt: assert property (p_kern_halt) else $error("no halt");
  property p_halt_sticky;
    halt_out |=> halt_out;
  endproperty
  a_halt_sticky: assert property (p_halt_sticky) else $error("halt released");
  property p_trap_delay;
    issue_out && $past(instr_valid_in && is_trap_in) |-> ##[1:3] trap_redirect_out;
  endproperty
  a_trap_delay: assert property (p_trap_delay) else $error("trap redirect late");
  property p_miss;
    $rose(cache_miss_in) |=> !issue_out [*8];
  endproperty
  a_miss: assert property (p_miss) else $error("issue during miss");
  property p_io;
    instr_valid_in && is_io_in && (io_busy_in || io_bus_stall_in) |=> !issue_out;
  endproperty
  a_io: assert property (p_io) else $error("io issued while busy");
endmodule // issue_stall_chk
bind issue_stall_ctrl issue_stall_chk chk_i (.*);

//--- cp_model.sv
`timescale 1ns/1ps
module cp_model (
  // clock and reset
  input  wire       ref_clk_in,
  input  wire       reset_in,
  // operation issued
  input  wire       go_in,
  input  wire [1:0] fmt_in,
  input  wire [1:0] op_in,
  input  wire       early_in,
  // completion
  output wire       done_out
);
  reg [5:0] cnt_reg;
  reg [5:0] lat;
  always @* begin
    case ({fmt_in, op_in})
      4'h_0, 4'h_4: lat = 6'd4;
      4'h_1:        lat = 6'd8;
      4'h_2:        lat = 6'd29;
      4'h_3, 4'h_7: lat = 6'd3;
      4'h_5:        lat = 6'd18;
      4'h_6:        lat = 6'd58;
      4'h_8:        lat = 6'd1;
      4'h_9:        lat = 6'd6;
      default:      lat = 6'd34;
    endcase
  end
  // done lands on the cycle the result is in, one earlier for a special add
  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in)
      cnt_reg <= 6'h00;
    else if (go_in)
      cnt_reg <= (lat > early_in + 2) ? lat - early_in - 6'd2 : 6'h00;
    else if (cnt_reg != 6'h00)
      cnt_reg <= cnt_reg - 6'h01;
  end
  assign done_out = cnt_reg == 6'h01;
endmodule // cp_model

//--- cpu_issue_and_stall_logic_tb.sv
`timescale 1ns/1ps
module cpu_issue_and_stall_logic_tb;
  reg ref_clk_in = 0, reset_in = 1, instr_valid_in = 0, kernel_mode_in = 0, is_load_in = 0,
    is_store_in = 0, is_trap_in = 0, is_io_in = 0, is_flush_in = 0, writes_reg_in = 0,
    cache_miss_in = 0, flush_line_in = 0, flush_dirty_in = 0, flush_done_in = 0,
    cp_issue_in = 0, io_busy_in = 0, io_bus_stall_in = 0, early = 0;
  reg  [31:0] instr_in = 0, instr_pc_in = 0, dest_data_in = 0, base_data_in = 0;
  reg  [5:0]  write_reg_in = 0;
  reg  [1:0]  cp_format_in = 0, cp_op_in = 0;
  wire        cp_done_in, issue_out, stall_out, halt_out, trap_redirect_out, rf_write_out;
  wire [31:0] program_status_word_out, trapping_pc_slot_out, next_pc_slot_out, result_latch_out,
    a_operand_latch_out, b_operand_latch_out, dcache_address_reg_out, rf_write_data_out;
  wire [5:0]  rf_write_addr_out;
  integer     fails = 0, num_checks = 0, n, m, k;
  int         lat [12] = '{4, 8, 29, 3, 4, 18, 58, 3, 1, 6, 34, 0};
  always #4 ref_clk_in = ~ref_clk_in;
  issue_stall_ctrl dut (.*);
  cp_model cop (.ref_clk_in, .reset_in, .go_in(issue_out && cp_issue_in), .fmt_in(cp_format_in),
    .op_in(cp_op_in), .early_in(early), .done_out(cp_done_in));
  task give_verdict;
    if (fails == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task tick;
    @(posedge ref_clk_in);
    #1;
  endtask
  task idle;
    @(posedge ref_clk_in) instr_valid_in <= 0;
    #1;
  endtask
  // cls = {cp, io, trap, store, load, writes}; n counts the cycles held off
  task send(input [31:0] i, input [5:0] cls, input [1:0] f = 0, input [1:0] o = 0);
    @(posedge ref_clk_in);
    instr_valid_in <= 1;
    instr_in <= i;
    instr_pc_in <= instr_pc_in + 32'h0000_0001;
    write_reg_in <= i[27:22];
    {cp_issue_in, is_io_in, is_trap_in, is_store_in, is_load_in, writes_reg_in} <= cls;
    {cp_format_in, cp_op_in} <= {f, o};
    n = -1;
    do begin tick; n++; end while (issue_out !== 1'b1 && n < 99);
    if (n == 99) begin fails++; give_verdict; end
  endtask
  task t_la;
    @(posedge ref_clk_in) base_data_in <= 32'h0000_1000;
    send(32'h D141_FFFC, 6'h01);
    chk(dcache_address_reg_out, 32'h0000_03FC);
    idle;
    chk(result_latch_out, 32'h0000_03FC);
    tick;
    chk(rf_write_data_out, 32'h0000_03FC);
    chk(rf_write_addr_out, 6'h05);
    send(32'hD185_0000, 6'h01);
    m = n;
    send(32'hD1C1_0000, 6'h01);
    chk(m - n, 1);
    send(32'h1000_0000, 6'h04);
    send(32'h1000_0000, 6'h02);
    m = n;
    send(32'h1000_0000, 6'h02);
    chk(m - n, 1);
    idle;
  endtask
  task t_stalls;
    @(posedge ref_clk_in) cache_miss_in <= 1;
    @(posedge ref_clk_in) cache_miss_in <= 0;
    send(32'h1000_0000, 6'h00);
    chk(n > 8 && n < 12, 1);
    idle;
    // one dirty line: thirteen cycles from the line report
    @(posedge ref_clk_in) {is_flush_in, flush_line_in, flush_dirty_in} <= 3'b111;
    fork
      send(32'h1000_0000, 6'h00);
      begin
        @(posedge ref_clk_in) flush_line_in <= 0;
        repeat (2) @(posedge ref_clk_in);
        flush_done_in <= 1;
      end
    join
    chk(n, 12);
    @(posedge ref_clk_in) {is_flush_in, flush_dirty_in, flush_done_in} <= 3'b000;
    idle;
    @(posedge ref_clk_in) {io_busy_in, io_bus_stall_in} <= 2'b11;
    fork
      send(32'h1000_0000, 6'h10);
      begin
        repeat (3) @(posedge ref_clk_in);
        io_busy_in <= 0;
        repeat (3) @(posedge ref_clk_in);
        io_bus_stall_in <= 0;
      end
    join
    chk(n > 4 && n < 7, 1);
    idle;
  endtask
  task t_cp;
    for (k = 0; k < 11; k++) begin
      send(32'h1000_0000, 6'h20, k[3:2], k[1:0]);
      send(32'h1000_0000, 6'h20, 2'h2, 2'h0);
      // the next word is first seen two edges after the issue edge
      chk(n, lat[k] > 2 ? lat[k] - 2 : 0);
    end
    @(posedge ref_clk_in) early <= 1;
    send(32'h1000_0000, 6'h20, 2'h0, 2'h0);
    send(32'h1000_0000, 6'h20, 2'h2, 2'h0);
    chk(n, 1);
    @(posedge ref_clk_in) early <= 0;
    idle;
  endtask
  task wait_redirect;
    k = 0;
    while (trap_redirect_out !== 1'b1 && k < 9) begin tick; k++; end
    chk(k, 2);
  endtask
  task t_traps;
    send(32'hE000_0000, 6'h00);
    idle;
    wait_redirect;
    chk(program_status_word_out[0], 1);
    chk(trapping_pc_slot_out, instr_pc_in);
    chk(next_pc_slot_out, instr_pc_in + 1);
    send(32'h1000_0000, 6'h08);
    idle;
    wait_redirect;
    @(posedge ref_clk_in) {kernel_mode_in, dest_data_in, base_data_in} <= {1'b1,
      32'hAAAA_0001, 32'h5555_0002};
    send(32'hF0C2_0000, 6'h00);
    idle;
    repeat (4) tick;
    chk(halt_out, 1);
    chk(a_operand_latch_out, 32'hAAAA_0001);
    chk(b_operand_latch_out, 32'h5555_0002);
    chk(next_pc_slot_out, instr_pc_in + 1);
  endtask
  // halt is only left through reset, so the kernel case runs last
  initial begin
    repeat (16) @(posedge ref_clk_in);
    reset_in <= 0;
    t_la;
    t_stalls;
    t_cp;
    t_traps;
    give_verdict;
  end
endmodule // cpu_issue_and_stall_logic_tb
